// *** cbs_asserts.sv ***
// Port-level concurrent checks of the bus cycle sequencer
`timescale 1ns/1ps
module cbs_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_n,
  input wire logic timer_req,
  input wire cbs_pkg::cbs_dec_s dec,
  input wire cbs_pkg::cbs_core_s core,
  input wire logic [7:0] rdata,
  input wire cbs_pkg::cbs_bus_s bus,
  input wire logic opcode_fetch,
  input wire logic operand_read,
  input wire logic instr_last,
  input wire logic [2:0] push_count,
  input wire logic [cbs_pkg::PC_W-1:0] pc
);
  localparam logic [10:0] EXT_V = {cbs_pkg::PAGE_HI[2:0], cbs_pkg::EXT_VEC_LO};
  localparam logic [10:0] TMR_V = {cbs_pkg::PAGE_HI[2:0], cbs_pkg::TMR_VEC_LO};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_reset_seq;
    $fell(rst) |-> (bus.addr == 11'h7FE)[*6] ##1 (bus.addr == 11'h7FF)
      ##1 (bus.addr == cbs_pkg::ZERO_ADDR) ##1 opcode_fetch;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset fetch order wrong");

  property p_dir_read;
    (opcode_fetch && dec.kind == cbs_pkg::K_READ && dec.mode == cbs_pkg::M_DIR) |=>
      bus.rw ##1 (bus.addr == cbs_pkg::DUMMY_ADDR) ##1 (operand_read && instr_last);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direct read cycles wrong");

  property p_op_read;
    (opcode_fetch || operand_read) |-> bus.rw;
  endproperty
  a_op_read: assert property (p_op_read) else $error("fetch cycle not a read");

  property p_write_last;
    (instr_last && !bus.rw) |-> $past(bus.rw) && $past(bus.addr) == bus.addr;
  endproperty
  a_write_last: assert property (p_write_last) else $error("write not after read");

  property p_bsc;
    (opcode_fetch && dec.kind == cbs_pkg::K_BSC) |-> ##6 (instr_last && !bus.rw);
  endproperty
  a_bsc: assert property (p_bsc) else $error("bit set length wrong");

  property p_btb;
    (opcode_fetch && dec.kind == cbs_pkg::K_BTB) |-> ##9 (instr_last && bus.rw);
  endproperty
  a_btb: assert property (p_btb) else $error("bit branch length wrong");

  property p_tst;
    (opcode_fetch && dec.kind == cbs_pkg::K_TST && dec.mode == cbs_pkg::M_DIR) |->
      ##3 (bus.rw && operand_read)[*3] ##0 instr_last;
  endproperty
  a_tst: assert property (p_tst) else $error("test zero reads wrong");

  property p_call_tail;
    (push_count == 3'h2) |-> bus.rw && bus.addr == core.sp - cbs_pkg::JSR_IDLE_OFS
      && !$past(bus.rw) && $past(bus.addr) == core.sp - 11'h001 && ($past(bus.wdata) >> 3) == 8'h1F;
  endproperty
  a_call_tail: assert property (p_call_tail) else $error("call stack tail wrong");

  property p_int_stack;
    (push_count == 3'h5) |-> $past(bus.addr, 8) == core.sp && !$past(bus.rw, 8)
      && !$past(bus.rw, 4) && $past(bus.rw, 3) && $past(bus.addr, 3) == core.sp - 11'h005;
  endproperty
  a_int_stack: assert property (p_int_stack) else $error("entry stack wrong");

  property p_int_vec;
    (push_count == 3'h5) |-> bus.rw && ($past(bus.addr, 2) == EXT_V || $past(bus.addr, 2) == TMR_V)
      && bus.addr == $past(bus.addr, 2) + 11'h002;
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("entry vector wrong");

  c_call: cover property (push_count == 3'h2);
  c_int: cover property (push_count == 3'h5);
  c_btb: cover property (opcode_fetch && dec.kind == cbs_pkg::K_BTB);
endmodule

// *** cbs_cycle_sequencer.sv ***
// Machine cycle sequencer: address, read/write level and write data per cycle
// Contract
// RQ1: Bit set/clear direct: seven cycles, write last
// RQ2: Direct store: five cycles, read then write
// RQ3: Modify ops: two reads, write same location
// RQ4: Test zero: three operand reads, no write
// RQ5: Direct read ops: four cycles, dummy at 07F
// RQ6: Direct call: seven cycles, dummy 07F first
// RQ7: Extended call: eight cycles, dummy at XFF
// RQ8: Extended store: six cycles, XFF dummy read
// RQ9: Calls push low, high, then idle read
// RQ10: No offset: skip byte, dummy, index operand
// RQ11: Byte offset: two 07F dummies, index plus offset
// RQ12: Word offset: two XFF dummies before operand
// RQ13: Reset: eight cycles of vector fetch
// RQ14: Request sampled at last cycle, held in first
// RQ15: Entry pushes return, index, accumulator, flags
// RQ16: Cycle eight idle read, then vector bytes
// RQ17: External and timer vectors, final unusable read
// RQ18: Twelve bit counter uses page 0F
// RQ19: Unused high counter bits pushed as ones
// RQ20: Read level high except for writes
// RQ21: Branches four cycles, bit branch ten cycles
// RQ22: Vector fetch starts after reset release
`timescale 1ns/1ps
module cbs_cycle_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_n,
  input wire logic timer_req,
  input wire cbs_pkg::cbs_dec_s dec,
  input wire cbs_pkg::cbs_core_s core,
  input wire logic [7:0] rdata,
  output cbs_pkg::cbs_bus_s bus,
  output logic opcode_fetch,
  output logic operand_read,
  output logic instr_last,
  output logic [2:0] push_count,
  output logic [cbs_pkg::PC_W-1:0] pc
);

  cbs_pkg::cbs_state_e state_q;
  logic [3:0] cyc_q;
  logic [cbs_pkg::PC_W-1:0] pc_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  cbs_pkg::cbs_kind_e kind_q;
  cbs_pkg::cbs_mode_e mode_q;
  logic ext_q;
  logic irq_s1_q;
  logic irq_s2_q;

  logic irq_low;
  logic pend;
  logic [3:0] plen;
  logic [3:0] tlen;
  logic [3:0] tidx;
  logic last;
  cbs_pkg::cbs_bop_e bop;
  logic [cbs_pkg::PC_W-1:0] ea;
  logic [7:0] vec_lo;

  // Address on the page that holds vectors
  function automatic logic [cbs_pkg::PC_W-1:0] page_addr(input logic [7:0] lo);
    logic [15:0] t;
    t = {cbs_pkg::PAGE_HI, lo};
    return t[cbs_pkg::PC_W-1:0];
  endfunction

  // High byte of the counter with unused bits set
  function automatic logic [7:0] hi_fill(input logic [cbs_pkg::PC_W-1:0] v);
    logic [15:0] t;
    t = {{(16 - cbs_pkg::PC_W){1'b1}}, v};
    return t[15:8];
  endfunction

  function automatic logic [cbs_pkg::PC_W-1:0] sext(input logic [7:0] b);
    logic [15:0] t;
    t = {{8{b[7]}}, b};
    return t[cbs_pkg::PC_W-1:0];
  endfunction

  function automatic logic [cbs_pkg::PC_W-1:0] zext(input logic [15:0] v);
    return v[cbs_pkg::PC_W-1:0];
  endfunction

  // Cycles up to and including the last addressing cycle
  function automatic logic [3:0] prefix_len(input cbs_pkg::cbs_mode_e m);
    logic [3:0] n;
    n = 4'h3;
    case (m)
      cbs_pkg::M_DIR: n = 4'h3;
      cbs_pkg::M_EXT: n = 4'h4;
      cbs_pkg::M_IX: n = 4'h3;
      cbs_pkg::M_IX1: n = 4'h4;
      cbs_pkg::M_IX2: n = 4'h5;
      cbs_pkg::M_REL: n = 4'h4;
      default: n = 4'h3;
    endcase
    return n;
  endfunction

  function automatic logic [3:0] tail_len(input cbs_pkg::cbs_kind_e k);
    logic [3:0] n;
    n = 4'h0;
    case (k)
      cbs_pkg::K_READ: n = 4'h1;
      cbs_pkg::K_STORE: n = 4'h2;
      cbs_pkg::K_RMW: n = 4'h3;
      cbs_pkg::K_TST: n = 4'h3;
      cbs_pkg::K_JMP: n = 4'h0;
      cbs_pkg::K_JSR: n = 4'h4;
      cbs_pkg::K_BSC: n = 4'h4;
      cbs_pkg::K_BTB: n = 4'h7;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  // Byte taken in a prefix cycle: 0 none, 1 high, 2 low
  function automatic logic [1:0] prefix_fetch(input cbs_pkg::cbs_mode_e m, input logic [3:0] s);
    logic [1:0] f;
    f = 2'h0;
    case (m)
      cbs_pkg::M_DIR: f = (s == 4'h2) ? 2'h2 : 2'h0;
      cbs_pkg::M_IX1: f = (s == 4'h2) ? 2'h2 : 2'h0;
      cbs_pkg::M_REL: f = (s == 4'h2) ? 2'h2 : 2'h0;
      cbs_pkg::M_EXT: f = (s == 4'h2) ? 2'h1 : ((s == 4'h3) ? 2'h2 : 2'h0);
      cbs_pkg::M_IX2: f = (s == 4'h2) ? 2'h1 : ((s == 4'h3) ? 2'h2 : 2'h0);
      default: f = 2'h0;
    endcase
    return f;
  endfunction

  function automatic cbs_pkg::cbs_bop_e prefix_op(input cbs_pkg::cbs_mode_e m,
                                                  input logic [3:0] s);
    cbs_pkg::cbs_bop_e o;
    o = cbs_pkg::BO_PC;
    case (m)
      cbs_pkg::M_DIR: o = (s == 4'h2) ? cbs_pkg::BO_PC : cbs_pkg::BO_DUMMY; // [RQ5]
      cbs_pkg::M_IX: o = (s == 4'h2) ? cbs_pkg::BO_PC : cbs_pkg::BO_DUMMY; // [RQ10]
      cbs_pkg::M_IX1: o = (s == 4'h2) ? cbs_pkg::BO_PC : cbs_pkg::BO_DUMMY; // [RQ11]
      cbs_pkg::M_EXT: o = (s == 4'h4) ? cbs_pkg::BO_XFF : cbs_pkg::BO_PC; // [RQ7] [RQ8]
      cbs_pkg::M_IX2: o = (s >= 4'h4) ? cbs_pkg::BO_XFF : cbs_pkg::BO_PC; // [RQ12]
      cbs_pkg::M_REL: o = cbs_pkg::BO_PC; // [RQ21]
      default: o = cbs_pkg::BO_PC;
    endcase
    return o;
  endfunction

  function automatic cbs_pkg::cbs_bop_e tail_op(input cbs_pkg::cbs_kind_e k,
                                                input logic [3:0] t);
    cbs_pkg::cbs_bop_e o;
    o = cbs_pkg::BO_EA_R;
    case (k)
      cbs_pkg::K_STORE: o = (t == 4'h1) ? cbs_pkg::BO_EA_W : cbs_pkg::BO_EA_R; // [RQ2]
      cbs_pkg::K_RMW: o = (t == 4'h2) ? cbs_pkg::BO_EA_W : cbs_pkg::BO_EA_R; // [RQ3]
      cbs_pkg::K_TST: o = cbs_pkg::BO_EA_R; // [RQ4]
      cbs_pkg::K_BSC: o = (t == 4'h3) ? cbs_pkg::BO_EA_W : cbs_pkg::BO_EA_R; // [RQ1]
      cbs_pkg::K_BTB: o = (t >= 4'h4) ? cbs_pkg::BO_PC : cbs_pkg::BO_EA_R; // [RQ21]
      cbs_pkg::K_JSR: begin
        case (t)
          4'h0: o = cbs_pkg::BO_EA_R; // [RQ6]
          4'h1: o = cbs_pkg::BO_PUSH_LO; // [RQ9]
          4'h2: o = cbs_pkg::BO_PUSH_HI; // [RQ9]
          default: o = cbs_pkg::BO_SP_IDLE; // [RQ9]
        endcase
      end
      default: o = cbs_pkg::BO_EA_R;
    endcase
    return o;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
    end else begin
      irq_s1_q <= irq_n;
      irq_s2_q <= irq_s1_q;
    end
  end

  assign irq_low = ~irq_s2_q;
  assign pend = ~core.imask & (irq_low | timer_req); // [RQ14]
  assign plen = prefix_len(mode_q);
  assign tlen = tail_len(kind_q);
  assign tidx = cyc_q - plen - 4'h1;
  assign vec_lo = ext_q ? cbs_pkg::EXT_VEC_LO : cbs_pkg::TMR_VEC_LO; // [RQ17]

  always_comb begin
    case (mode_q)
      cbs_pkg::M_DIR: ea = zext({8'h00, lo_q});
      cbs_pkg::M_EXT: ea = zext({hi_q, lo_q});
      cbs_pkg::M_IX: ea = zext({8'h00, core.idx}); // [RQ10]
      cbs_pkg::M_IX1: ea = zext({8'h00, core.idx} + {8'h00, lo_q}); // [RQ11]
      cbs_pkg::M_IX2: ea = zext({hi_q, lo_q} + {8'h00, core.idx}); // [RQ12]
      cbs_pkg::M_REL: ea = pc_q + sext(lo_q);
      default: ea = zext({8'h00, lo_q});
    endcase
  end

  always_comb begin
    bop = cbs_pkg::BO_PC;
    last = 1'b0;
    case (state_q)
      cbs_pkg::ST_RESET: begin
        if (cyc_q <= cbs_pkg::RST_HI_LAST) begin
          bop = cbs_pkg::BO_RST_HI; // [RQ13]
        end else if (cyc_q == cbs_pkg::RST_LO_CYC) begin
          bop = cbs_pkg::BO_RST_LO; // [RQ13]
        end else begin
          bop = cbs_pkg::BO_ZERO; // [RQ13]
        end
      end
      cbs_pkg::ST_OP: begin
        bop = cbs_pkg::BO_PC;
      end
      cbs_pkg::ST_EXEC: begin
        if (cyc_q <= plen) begin
          bop = prefix_op(mode_q, cyc_q);
        end else begin
          bop = tail_op(kind_q, tidx);
        end
        last = (cyc_q == plen + tlen);
      end
      cbs_pkg::ST_INT: begin
        case (cyc_q)
          4'h1: bop = cbs_pkg::BO_PC;
          4'h2: bop = cbs_pkg::BO_PC;
          4'h3: bop = cbs_pkg::BO_PUSH_LO; // [RQ15]
          4'h4: bop = cbs_pkg::BO_PUSH_HI; // [RQ15]
          4'h5: bop = cbs_pkg::BO_PUSH_X; // [RQ15]
          4'h6: bop = cbs_pkg::BO_PUSH_A; // [RQ15]
          4'h7: bop = cbs_pkg::BO_PUSH_CC; // [RQ15]
          4'h8: bop = cbs_pkg::BO_SP_IDLE; // [RQ16]
          4'h9: bop = cbs_pkg::BO_VEC_HI; // [RQ16]
          4'hA: bop = cbs_pkg::BO_VEC_LO; // [RQ16]
          default: bop = cbs_pkg::BO_VEC_NEXT; // [RQ17]
        endcase
        last = (cyc_q == cbs_pkg::INT_CYCLES);
      end
      default: bop = cbs_pkg::BO_PC;
    endcase
  end

  // Bus drive for the current cycle
  always_comb begin
    bus.addr = pc_q;
    bus.rw = 1'b1;
    bus.wdata = 8'h00;
    case (bop)
      cbs_pkg::BO_PC: bus.addr = pc_q;
      cbs_pkg::BO_DUMMY: bus.addr = cbs_pkg::DUMMY_ADDR;
      cbs_pkg::BO_XFF: bus.addr = {pc_q[cbs_pkg::PC_W-1:8], cbs_pkg::PAGE_LAST_LO};
      cbs_pkg::BO_EA_R: bus.addr = ea;
      cbs_pkg::BO_EA_W: begin
        bus.addr = ea;
        bus.rw = 1'b0; // [RQ20]
        bus.wdata = core.mdata;
      end
      cbs_pkg::BO_PUSH_LO: begin
        bus.addr = core.sp;
        bus.rw = 1'b0;
        bus.wdata = pc_q[7:0];
      end
      cbs_pkg::BO_PUSH_HI: begin
        bus.addr = core.sp - 11'h001;
        bus.rw = 1'b0;
        bus.wdata = hi_fill(pc_q); // [RQ19]
      end
      cbs_pkg::BO_PUSH_X: begin
        bus.addr = core.sp - 11'h002;
        bus.rw = 1'b0;
        bus.wdata = core.idx;
      end
      cbs_pkg::BO_PUSH_A: begin
        bus.addr = core.sp - 11'h003;
        bus.rw = 1'b0;
        bus.wdata = core.acc;
      end
      cbs_pkg::BO_PUSH_CC: begin
        bus.addr = core.sp - 11'h004;
        bus.rw = 1'b0;
        bus.wdata = core.ccr;
      end
      cbs_pkg::BO_SP_IDLE: begin
        if (state_q == cbs_pkg::ST_INT) begin
          bus.addr = core.sp - cbs_pkg::INT_IDLE_OFS;
        end else begin
          bus.addr = core.sp - cbs_pkg::JSR_IDLE_OFS;
        end
      end
      cbs_pkg::BO_VEC_HI: bus.addr = page_addr(vec_lo); // [RQ18]
      cbs_pkg::BO_VEC_LO: bus.addr = page_addr(vec_lo + 8'h01);
      cbs_pkg::BO_VEC_NEXT: bus.addr = page_addr(vec_lo + 8'h02);
      cbs_pkg::BO_RST_HI: bus.addr = page_addr(cbs_pkg::RST_VEC_HI_LO);
      cbs_pkg::BO_RST_LO: bus.addr = page_addr(cbs_pkg::RST_VEC_LO_LO);
      cbs_pkg::BO_ZERO: bus.addr = cbs_pkg::ZERO_ADDR;
      default: bus.addr = pc_q;
    endcase
  end

  assign opcode_fetch = (state_q == cbs_pkg::ST_OP);
  assign operand_read = (bop == cbs_pkg::BO_EA_R) && (state_q == cbs_pkg::ST_EXEC);
  assign instr_last = last && (state_q == cbs_pkg::ST_EXEC);
  assign pc = pc_q;

  always_comb begin
    push_count = 3'h0;
    if (last && (state_q == cbs_pkg::ST_INT)) begin
      push_count = cbs_pkg::INT_PUSHES;
    end else if (instr_last && (kind_q == cbs_pkg::K_JSR)) begin
      push_count = cbs_pkg::JSR_PUSHES;
    end
  end

  // Sequencing of states and cycle numbers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= cbs_pkg::ST_RESET; // [RQ22]
      cyc_q <= 4'h1;
      kind_q <= cbs_pkg::K_READ;
      mode_q <= cbs_pkg::M_DIR;
      ext_q <= 1'b0;
    end else begin
      case (state_q)
        cbs_pkg::ST_RESET: begin
          if (cyc_q == cbs_pkg::RST_CYCLES) begin
            state_q <= cbs_pkg::ST_OP;
          end
          cyc_q <= cyc_q + 4'h1;
        end
        cbs_pkg::ST_OP: begin
          kind_q <= dec.kind;
          mode_q <= dec.mode;
          state_q <= cbs_pkg::ST_EXEC;
          cyc_q <= 4'h2;
        end
        cbs_pkg::ST_EXEC: begin
          if (last) begin
            state_q <= pend ? cbs_pkg::ST_INT : cbs_pkg::ST_OP; // [RQ14]
            cyc_q <= 4'h1;
          end else begin
            cyc_q <= cyc_q + 4'h1;
          end
        end
        cbs_pkg::ST_INT: begin
          if (cyc_q == 4'h1) begin
            ext_q <= irq_low;
            if (!(irq_low || timer_req)) begin
              state_q <= cbs_pkg::ST_OP; // [RQ14]
            end
          end
          if (last) begin
            state_q <= cbs_pkg::ST_OP;
            cyc_q <= 4'h1;
          end else begin
            cyc_q <= cyc_q + 4'h1;
          end
        end
        default: state_q <= cbs_pkg::ST_RESET;
      endcase
    end
  end

  // Captured address bytes and program counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_q <= '0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      case (state_q)
        cbs_pkg::ST_RESET: begin
          if (cyc_q == cbs_pkg::RST_HI_LAST) begin
            hi_q <= rdata;
          end
          if (cyc_q == cbs_pkg::RST_LO_CYC) begin
            lo_q <= rdata;
          end
          if (cyc_q == cbs_pkg::RST_CYCLES) begin
            pc_q <= zext({hi_q, lo_q});
          end
        end
        cbs_pkg::ST_OP: begin
          pc_q <= pc_q + 11'h001;
        end
        cbs_pkg::ST_EXEC: begin
          if (cyc_q <= plen) begin
            if (prefix_fetch(mode_q, cyc_q) == 2'h1) begin
              hi_q <= rdata;
              pc_q <= pc_q + 11'h001;
            end else if (prefix_fetch(mode_q, cyc_q) == 2'h2) begin
              lo_q <= rdata;
              pc_q <= pc_q + 11'h001;
            end
          end else if (kind_q == cbs_pkg::K_BTB && tidx == 4'h4) begin
            hi_q <= rdata; // [RQ21]
            pc_q <= pc_q + 11'h001;
          end
          if (last) begin
            if (kind_q == cbs_pkg::K_JSR) begin
              pc_q <= ea;
            end else if (kind_q == cbs_pkg::K_JMP) begin
              if (mode_q != cbs_pkg::M_REL || core.take) begin
                pc_q <= ea;
              end
            end else if (kind_q == cbs_pkg::K_BTB && core.take) begin
              pc_q <= pc_q + sext(hi_q);
            end
          end
        end
        cbs_pkg::ST_INT: begin
          if (cyc_q == 4'h9) begin
            hi_q <= rdata;
          end
          if (cyc_q == 4'hA) begin
            lo_q <= rdata;
          end
          if (last) begin
            pc_q <= zext({hi_q, lo_q});
          end
        end
        default: pc_q <= pc_q;
      endcase
    end
  end

endmodule

// *** cbs_cycle_sequencer_tb.sv ***
// Self-checking testbench of the bus cycle sequencer
`timescale 1ns/1ps
module cbs_cycle_sequencer_tb;
  localparam logic [10:0] RST_V = {cbs_pkg::PAGE_HI[2:0], cbs_pkg::RST_VEC_HI_LO};
  localparam logic [10:0] EXT_V = {cbs_pkg::PAGE_HI[2:0], cbs_pkg::EXT_VEC_LO};
  localparam logic [10:0] TMR_V = {cbs_pkg::PAGE_HI[2:0], cbs_pkg::TMR_VEC_LO};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic irq_n = 1'b1;
  logic timer_req = 1'b0;
  cbs_pkg::cbs_dec_s dec = '0;
  cbs_pkg::cbs_core_s core = '{8'hA5, 8'h05, 8'hC3, 11'h060, 8'h3C, 1'b1, 1'b0};
  logic [7:0] rdata;
  cbs_pkg::cbs_bus_s bus;
  logic opcode_fetch;
  logic operand_read;
  logic instr_last;
  logic [2:0] push_count;
  logic [cbs_pkg::PC_W-1:0] pc;
  logic [10:0] op_addr = 11'h000;
  int failures = 0;
  int cmp_count = 0;

  always #5 mclk = ~mclk;

  cbs_cycle_sequencer u_cbs_cycle_sequencer (.mclk(mclk), .rst(rst), .irq_n(irq_n),
    .timer_req(timer_req), .dec(dec), .core(core), .rdata(rdata), .bus(bus),
    .opcode_fetch(opcode_fetch), .operand_read(operand_read), .instr_last(instr_last),
    .push_count(push_count), .pc(pc));
  cbs_mem_model u_cbs_mem_model (.mclk(mclk), .bus(bus), .rdata(rdata));

  task cmp_cyc(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t addr_rw got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t value got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One code letter per cycle; fl is {instr_last, push_count} of the final cycle
  task automatic run(input cbs_pkg::cbs_kind_e k, input cbs_pkg::cbs_mode_e m, input string s,
    input logic [10:0] ea, input logic [10:0] ret, input logic [3:0] fl, input logic [10:0] nxt);
    logic [10:0] p;
    logic [10:0] a;
    logic r;
    logic [7:0] wd;
    p = op_addr;
    dec = '{k, m};
    for (int i = 0; i < s.len(); i++) begin
      r = 1'b1;
      wd = 8'h00;
      case (s[i])
        "P": a = p;
        "1", "2", "3": a = p + 11'(s[i] - 8'h30);
        "D": a = cbs_pkg::DUMMY_ADDR;
        "F": a = {p[10:8], cbs_pkg::PAGE_LAST_LO};
        "E", "H": a = ea;
        "L": a = ea + 11'h001;
        "N": a = ea + 11'h002;
        "0": a = cbs_pkg::ZERO_ADDR;
        "U": a = core.sp - 11'h002;
        "5": a = core.sp - 11'h005;
        "W": {a, r, wd} = {ea, 1'b0, core.mdata};
        "S": {a, r, wd} = {core.sp, 1'b0, ret[7:0]};
        "T": {a, r, wd} = {core.sp - 11'h001, 1'b0, 5'h1F, ret[10:8]};
        "X": {a, r, wd} = {core.sp - 11'h002, 1'b0, core.idx};
        "A": {a, r, wd} = {core.sp - 11'h003, 1'b0, core.acc};
        default: {a, r, wd} = {core.sp - 11'h004, 1'b0, core.ccr};
      endcase
      @(negedge mclk);
      cmp_cyc({bus.addr, bus.rw}, {a, r});
      if (!r) cmp_val(bus.wdata, wd);
      if (i == s.len() - 1) cmp_val({4'h0, instr_last, push_count}, {4'h0, fl});
      @(posedge mclk);
      #1;
    end
    cmp_cyc({pc, 1'b1}, {nxt, 1'b1});
    op_addr = nxt;
  endtask

  task t_reset;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "HHHHHHL0", RST_V, 11'h0, 4'h0, 11'h100);
  endtask

  task t_direct;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "P1DE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_STORE, cbs_pkg::M_DIR, "P1DEW", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_BSC, cbs_pkg::M_DIR, "P1DEEEW", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_TST, cbs_pkg::M_DIR, "P1DEEE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
  endtask

  task t_indexed;
    run(cbs_pkg::K_RMW, cbs_pkg::M_IX1, "P1DDEEW", 11'h045, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_RMW, cbs_pkg::M_IX, "P1DEEW", 11'h005, 11'h0, 4'h8, op_addr + 11'h001);
    run(cbs_pkg::K_READ, cbs_pkg::M_IX, "P1DE", 11'h005, 11'h0, 4'h8, op_addr + 11'h001);
    run(cbs_pkg::K_READ, cbs_pkg::M_IX2, "P12FFE", 11'h045, 11'h0, 4'h8, op_addr + 11'h003);
    run(cbs_pkg::K_STORE, cbs_pkg::M_EXT, "P12FEW", 11'h040, 11'h0, 4'h8, op_addr + 11'h003);
  endtask

  task t_branch;
    run(cbs_pkg::K_JMP, cbs_pkg::M_REL, "P122", 11'h0, 11'h0, 4'h8, op_addr + 11'h042);
    core.take = 1'b0;
    run(cbs_pkg::K_JMP, cbs_pkg::M_REL, "P122", 11'h0, 11'h0, 4'h8, op_addr + 11'h002);
    core.take = 1'b1;
    run(cbs_pkg::K_BTB, cbs_pkg::M_DIR, "P1DEEEE233", 11'h040, 11'h0, 4'h8, op_addr + 11'h043);
  endtask

  task t_interrupts;
    core.imask = 1'b1;
    timer_req = 1'b1;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "P1DE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    core.imask = 1'b0;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "P1DE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    // Request dropped in entry cycle 1: entry abandoned, opcode fetched next
    timer_req = 1'b0;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "PP1DE", 11'h040, 11'h0, 4'h8,
      op_addr + 11'h002);
    timer_req = 1'b1;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "P1DE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "PPSTXAC5HLN", TMR_V, op_addr, 4'h5, 11'h300);
    timer_req = 1'b0;
    irq_n = 1'b0;
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "P1DE", 11'h040, 11'h0, 4'h8, op_addr + 11'h002);
    run(cbs_pkg::K_READ, cbs_pkg::M_DIR, "PPSTXAC5HLN", EXT_V, op_addr, 4'h5, 11'h200);
    irq_n = 1'b1;
  endtask

  task t_calls;
    run(cbs_pkg::K_JSR, cbs_pkg::M_DIR, "P1DESTU", 11'h040, op_addr + 11'h002, 4'hA, 11'h040);
    run(cbs_pkg::K_JSR, cbs_pkg::M_EXT, "P12FESTU", 11'h040, op_addr + 11'h003, 4'hA, 11'h040);
    run(cbs_pkg::K_JSR, cbs_pkg::M_REL, "P122ESTU", op_addr + 11'h042, op_addr + 11'h002, 4'hA,
      op_addr + 11'h042);
  endtask

  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset;
    t_direct;
    t_indexed;
    t_branch;
    t_interrupts;
    t_calls;
    results;
  end

  initial begin
    #5000;
    failures++;
    results;
  end
endmodule

bind cbs_cycle_sequencer cbs_asserts u_cbs_asserts (.mclk(mclk), .rst(rst), .irq_n(irq_n),
  .timer_req(timer_req), .dec(dec), .core(core), .rdata(rdata), .bus(bus),
  .opcode_fetch(opcode_fetch), .operand_read(operand_read), .instr_last(instr_last),
  .push_count(push_count), .pc(pc));

// *** cbs_mem_model.sv ***
// Zero-wait program, data and stack memory on the core bus
`timescale 1ns/1ps
module cbs_mem_model (
  input wire logic mclk,
  input wire cbs_pkg::cbs_bus_s bus,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:2047];
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'h40;
    mem[11'h7F8] = 8'h03;
    mem[11'h7F9] = 8'h00;
    mem[11'h7FA] = 8'h02;
    mem[11'h7FB] = 8'h00;
    mem[11'h7FE] = 8'h01;
    mem[11'h7FF] = 8'h00;
  end
  assign rdata = mem[bus.addr];
  always @(posedge mclk) begin
    if (bus.rw == 1'b0) begin
      mem[bus.addr] <= bus.wdata;
    end
  end
endmodule

// *** cbs_pkg.sv ***
// Shared constants, enumerations and carriers of the bus cycle sequencer
package cbs_pkg;
  localparam int PC_W = 11;
  localparam logic [7:0] PAGE_HI = (PC_W == 12) ? 8'h0F : 8'h07;
  localparam logic [PC_W-1:0] DUMMY_ADDR = 11'h07F;
  localparam logic [PC_W-1:0] ZERO_ADDR = 11'h000;
  localparam logic [7:0] PAGE_LAST_LO = 8'hFF;
  localparam logic [7:0] RST_VEC_HI_LO = 8'hFE;
  localparam logic [7:0] RST_VEC_LO_LO = 8'hFF;
  localparam logic [7:0] EXT_VEC_LO = 8'hFA;
  localparam logic [7:0] TMR_VEC_LO = 8'hF8;
  localparam logic [3:0] RST_HI_LAST = 4'h6;
  localparam logic [3:0] RST_LO_CYC = 4'h7;
  localparam logic [3:0] RST_CYCLES = 4'h8;
  localparam logic [3:0] INT_CYCLES = 4'hB;
  localparam logic [2:0] JSR_PUSHES = 3'h2;
  localparam logic [2:0] INT_PUSHES = 3'h5;
  localparam logic [PC_W-1:0] JSR_IDLE_OFS = 11'h002;
  localparam logic [PC_W-1:0] INT_IDLE_OFS = 11'h005;

  typedef enum logic [2:0] {
    K_READ = 3'b000,
    K_STORE = 3'b001,
    K_RMW = 3'b010,
    K_TST = 3'b011,
    K_JMP = 3'b100,
    K_JSR = 3'b101,
    K_BSC = 3'b110,
    K_BTB = 3'b111
  } cbs_kind_e;

  typedef enum logic [2:0] {
    M_DIR = 3'b000,
    M_EXT = 3'b001,
    M_IX = 3'b010,
    M_IX1 = 3'b011,
    M_IX2 = 3'b100,
    M_REL = 3'b101
  } cbs_mode_e;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_OP = 2'b01,
    ST_EXEC = 2'b10,
    ST_INT = 2'b11
  } cbs_state_e;

  typedef enum logic [4:0] {
    BO_PC = 5'b00000,
    BO_DUMMY = 5'b00001,
    BO_XFF = 5'b00010,
    BO_EA_R = 5'b00011,
    BO_EA_W = 5'b00100,
    BO_PUSH_LO = 5'b00101,
    BO_PUSH_HI = 5'b00110,
    BO_PUSH_X = 5'b00111,
    BO_PUSH_A = 5'b01000,
    BO_PUSH_CC = 5'b01001,
    BO_SP_IDLE = 5'b01010,
    BO_VEC_HI = 5'b01011,
    BO_VEC_LO = 5'b01100,
    BO_VEC_NEXT = 5'b01101,
    BO_RST_HI = 5'b01110,
    BO_RST_LO = 5'b01111,
    BO_ZERO = 5'b10000
  } cbs_bop_e;

  typedef struct packed {
    cbs_kind_e kind;
    cbs_mode_e mode;
  } cbs_dec_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [7:0] ccr;
    logic [PC_W-1:0] sp;
    logic [7:0] mdata;
    logic take;
    logic imask;
  } cbs_core_s;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic rw;
    logic [7:0] wdata;
  } cbs_bus_s;
endpackage
